// ---- src/cifs_mode_tracker.sv ----
// tracks the operating mode and pulses when current reaches the request
`timescale 1ns/1ps
module cifs_mode_tracker
   import cifs_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic [MODE_W-1:0] current_operating_mode,
   input  wire logic [MODE_W-1:0] requested_operating_mode,
   output logic                   mode_reached
);
   logic [MODE_W-1:0] last_mode;
   // a change of the current mode that lands on the request is the event
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         last_mode    <= MODE_RESET;
         mode_reached <= 1'b0;
      end else begin
         last_mode    <= current_operating_mode;
         mode_reached <= (current_operating_mode != last_mode)
                         && (current_operating_mode == requested_operating_mode);
      end
   end
endmodule

// ---- src/cifs_pkg.sv ----
// shared constants for the can interrupt flag and status block
package cifs_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int FIFO_N = 8;
   localparam int MODE_W = 3;
   localparam int TS_W   = 32;
   // register offsets (word index on the plain register port)
   localparam logic [ADDR_W-1:0] OFS_FLAGS      = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_ENABLES    = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_RX_PEND_LO = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_RX_PEND_HI = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_MODE       = 4'h4;
   // flag bit positions, shared by the flag and enable registers
   localparam int BIT_IVM  = 15;
   localparam int BIT_WAK  = 14;
   localparam int BIT_CERR = 13;
   localparam int BIT_SERR = 12;
   localparam int BIT_RXOV = 11;
   localparam int BIT_TXAT = 10;
   localparam int BIT_TEF  = 4;
   localparam int BIT_MOD  = 3;
   localparam int BIT_TBC  = 2;
   localparam int BIT_RX   = 1;
   localparam int BIT_TX   = 0;
   // writable enable bits; 9..5 stay zero
   localparam logic [DATA_W-1:0] ENABLE_MASK = 16'hFC1F;
   localparam logic [DATA_W-1:0] ZERO_WORD   = 16'h0000;
   localparam logic [FIFO_N-1:0] RX_FIFO_MASK = 8'hFE;
   localparam logic [MODE_W-1:0] MODE_RESET  = 3'h4;
   localparam logic [TS_W-1:0]   TS_MAX      = 32'hFFFF_FFFF;
endpackage

// ---- src/cifs_sticky_flag.sv ----
// one hardware-set, software-cleared flag bit
`timescale 1ns/1ps
module cifs_sticky_flag (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic set_event,
   input  wire logic clear_req,
   output logic      flag
);
   // set beats clear so an event in the clearing cycle is kept
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         flag <= 1'b0;
      end else if (set_event) begin
         flag <= 1'b1;
      end else if (clear_req) begin
         flag <= 1'b0;
      end
   end
endmodule

// ---- src/cifs_top.sv ----
// can interrupt flag and status aggregation with its register port
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module cifs_top
   import cifs_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  sys_rst,
   input  wire logic [cifs_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [cifs_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                  reg_write,
   input  wire logic                  reg_read,
   output logic [cifs_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic                  invalid_message_event,
   input  wire logic                  wake_activity_event,
   input  wire logic                  bus_error_event,
   input  wire logic                  system_error_event,
   input  wire logic [cifs_pkg::MODE_W-1:0] current_operating_mode,
   input  wire logic [cifs_pkg::MODE_W-1:0] requested_operating_mode,
   input  wire logic [cifs_pkg::TS_W-1:0]   timestamp_counter,
   input  wire logic [cifs_pkg::FIFO_N-1:0] rx_fifo_flags,
   input  wire logic [cifs_pkg::FIFO_N-1:0] rx_fifo_flag_enables,
   input  wire logic [cifs_pkg::FIFO_N-1:0] rx_overflow_flags,
   input  wire logic [cifs_pkg::FIFO_N-1:0] tx_attempt_flags,
   input  wire logic                  tx_event_queue_flag,
   input  wire logic [cifs_pkg::FIFO_N-1:0] tx_fifo_pending,
   output logic                       irq_request
);

   ////////////////////////////////////////////////////////////////////////////
   // event capture
   ////////////////////////////////////////////////////////////////////////////

   logic [TS_W-1:0] last_timestamp;
   logic            mode_reached;
   logic            invalid_message_flag;
   logic            wake_activity_flag;
   logic            bus_error_flag;
   logic            system_error_flag;
   logic            mode_change_flag;
   logic            timebase_wrap_flag;
   logic [DATA_W-1:0] enables;
   logic [DATA_W-1:0] next_enables;

   // wrap is seen as the counter leaving its maximum to a smaller value
   wire timebase_wrap = (last_timestamp == TS_MAX) && (timestamp_counter != TS_MAX);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         last_timestamp <= {TS_W{1'b0}}; // a maximum here would fake a wrap on the first edge out of reset
      end else begin
         last_timestamp <= timestamp_counter;
      end
   end

   cifs_mode_tracker u_mode (
      .sys_clk                  (sys_clk),
      .sys_rst                  (sys_rst),
      .current_operating_mode   (current_operating_mode),
      .requested_operating_mode (requested_operating_mode),
      .mode_reached             (mode_reached)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register decode
   ////////////////////////////////////////////////////////////////////////////

   wire wr_flags   = reg_write && (reg_addr == OFS_FLAGS);
   wire wr_enables = reg_write && (reg_addr == OFS_ENABLES);

   // a written zero clears; the bus only reaches the six event flags
   wire clr_ivm  = wr_flags && !reg_wdata[BIT_IVM];
   wire clr_wak  = wr_flags && !reg_wdata[BIT_WAK];
   wire clr_cerr = wr_flags && !reg_wdata[BIT_CERR];
   wire clr_serr = wr_flags && !reg_wdata[BIT_SERR];
   wire clr_mod  = wr_flags && !reg_wdata[BIT_MOD];
   wire clr_tbc  = wr_flags && !reg_wdata[BIT_TBC];

   ////////////////////////////////////////////////////////////////////////////
   // sticky event flags, only hardware sets them
   ////////////////////////////////////////////////////////////////////////////

   cifs_sticky_flag u_ivm (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .set_event (invalid_message_event),
      .clear_req (clr_ivm),
      .flag      (invalid_message_flag)
   );

   cifs_sticky_flag u_wak (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .set_event (wake_activity_event),
      .clear_req (clr_wak),
      .flag      (wake_activity_flag)
   );

   cifs_sticky_flag u_cerr (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .set_event (bus_error_event),
      .clear_req (clr_cerr),
      .flag      (bus_error_flag)
   );

   cifs_sticky_flag u_serr (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .set_event (system_error_event),
      .clear_req (clr_serr),
      .flag      (system_error_flag)
   );

   cifs_sticky_flag u_mod (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .set_event (mode_reached),
      .clear_req (clr_mod),
      .flag      (mode_change_flag)
   );

   cifs_sticky_flag u_tbc (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .set_event (timebase_wrap),
      .clear_req (clr_tbc),
      .flag      (timebase_wrap_flag)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read-only summaries, combinational from their sources
   ////////////////////////////////////////////////////////////////////////////

   // fifo 0 is masked out because it never receives
   wire [FIFO_N-1:0] rx_fifo_pending = rx_fifo_flags & rx_fifo_flag_enables & RX_FIFO_MASK;
   wire rx_overflow_summary    = |(rx_overflow_flags & RX_FIFO_MASK);
   wire tx_attempt_summary     = |tx_attempt_flags;
   wire tx_event_queue_summary = tx_event_queue_flag;
   wire rx_object_summary      = |rx_fifo_pending;
   wire tx_object_summary      = |tx_fifo_pending;

   // unlisted bits are left zero so 9..5 read back as zero
   logic [DATA_W-1:0] flag_word;
   always_comb begin
      flag_word           = ZERO_WORD;
      flag_word[BIT_IVM]  = invalid_message_flag;
      flag_word[BIT_WAK]  = wake_activity_flag;
      flag_word[BIT_CERR] = bus_error_flag;
      flag_word[BIT_SERR] = system_error_flag;
      flag_word[BIT_RXOV] = rx_overflow_summary;
      flag_word[BIT_TXAT] = tx_attempt_summary;
      flag_word[BIT_TEF]  = tx_event_queue_summary;
      flag_word[BIT_MOD]  = mode_change_flag;
      flag_word[BIT_TBC]  = timebase_wrap_flag;
      flag_word[BIT_RX]   = rx_object_summary;
      flag_word[BIT_TX]   = tx_object_summary;
   end

   wire [DATA_W-1:0] rx_pend_lo_word = {{(DATA_W-FIFO_N){1'b0}}, rx_fifo_pending};

   ////////////////////////////////////////////////////////////////////////////
   // enables and interrupt request
   ////////////////////////////////////////////////////////////////////////////

   assign next_enables = wr_enables ? (reg_wdata & ENABLE_MASK) : enables;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         enables <= ZERO_WORD;
      end else begin
         enables <= next_enables;
      end
   end

   wire next_irq = |(flag_word & enables);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irq_request <= 1'b0;
      end else begin
         irq_request <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port, data in the cycle after the strobe
   ////////////////////////////////////////////////////////////////////////////

   wire [DATA_W-1:0] mode_word = {{(DATA_W-2*MODE_W){1'b0}}, requested_operating_mode, current_operating_mode};
   logic [DATA_W-1:0] read_mux;

   // unmapped offsets and high pending word read as zero
   always_comb begin
      if (reg_addr == OFS_FLAGS) begin
         read_mux = flag_word;
      end else if (reg_addr == OFS_ENABLES) begin
         read_mux = enables;
      end else if (reg_addr == OFS_RX_PEND_LO) begin
         read_mux = rx_pend_lo_word;
      end else if (reg_addr == OFS_MODE) begin
         read_mux = mode_word;
      end else begin
         read_mux = ZERO_WORD;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata <= ZERO_WORD;
      end else if (reg_read) begin
         reg_rdata <= read_mux;
      end else begin
         reg_rdata <= ZERO_WORD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   ////////////////////////////////////////////////////////////////////////////

   // each event sets its flag at the next edge, a mode change at the second, even against a clearing write
   a_ivm_set_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
      invalid_message_event |=> invalid_message_flag)
      else $error("invalid message flag not set");
   a_wak_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wake_activity_event |=> wake_activity_flag)
      else $error("wake flag not set");
   a_cerr_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus_error_event |=> bus_error_flag)
      else $error("bus error flag not set");
   a_serr_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
      system_error_event |=> system_error_flag)
      else $error("system error flag not set");
   a_tbc_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
      timebase_wrap |=> timebase_wrap_flag)
      else $error("wrap not flagged");
   a_mode_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (current_operating_mode != $past(current_operating_mode)
       && current_operating_mode == requested_operating_mode) |=> ##1 mode_change_flag)
      else $error("mode change not flagged");

   // a written zero clears a flag unless its event lands in the same cycle; a one keeps it
   a_flag_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clr_ivm && !invalid_message_event) |=> !invalid_message_flag)
      else $error("flag not cleared");
   a_wak_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clr_wak && !wake_activity_event) |=> !wake_activity_flag)
      else $error("wake flag not cleared");
   a_cerr_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clr_cerr && !bus_error_event) |=> !bus_error_flag)
      else $error("bus error flag not cleared");
   a_serr_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clr_serr && !system_error_event) |=> !system_error_flag)
      else $error("system error flag not cleared");
   a_mod_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clr_mod && !mode_reached) |=> !mode_change_flag)
      else $error("mode flag not cleared");
   a_tbc_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clr_tbc && !timebase_wrap) |=> !timebase_wrap_flag)
      else $error("wrap flag not cleared");
   a_ivm_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_flags && reg_wdata[BIT_IVM] && invalid_message_flag) |=> invalid_message_flag)
      else $error("flag lost on a written one");

   // software can never raise a flag, only its hardware event can
   a_flag_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!invalid_message_event && $rose(invalid_message_flag)) |-> $past(invalid_message_event))
      else $error("flag rose without event");
   a_wak_rise: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(wake_activity_flag) |-> $past(wake_activity_event))
      else $error("wake flag rose without event");
   a_tbc_rise: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(timebase_wrap_flag) |-> $past(timebase_wrap))
      else $error("wrap flag rose without wrap");

   // a read returns the live summaries; reserved and unbacked positions read zero
   a_rxov_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_read && reg_addr == OFS_FLAGS && |(rx_overflow_flags & RX_FIFO_MASK)) |=> reg_rdata[BIT_RXOV])
      else $error("overflow summary missing");
   a_txat_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_read && reg_addr == OFS_FLAGS && |tx_attempt_flags) |=> reg_rdata[BIT_TXAT])
      else $error("attempt summary missing");
   a_tef_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_read && reg_addr == OFS_FLAGS && tx_event_queue_flag) |=> reg_rdata[BIT_TEF])
      else $error("event queue summary missing");
   a_tx_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_read && reg_addr == OFS_FLAGS && |tx_fifo_pending) |=> reg_rdata[BIT_TX])
      else $error("transmit object summary missing");
   a_rx_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_read && reg_addr == OFS_FLAGS && !(|rx_fifo_flags)) |=> !reg_rdata[BIT_RX])
      else $error("receive object summary without source");
   a_summ_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_read && reg_addr == OFS_FLAGS && !(|rx_overflow_flags) && !(|tx_attempt_flags) && !(|tx_fifo_pending))
      |=> (!reg_rdata[BIT_RXOV] && !reg_rdata[BIT_TXAT] && !reg_rdata[BIT_TX]))
      else $error("summary stuck after sources cleared");
   a_read_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_read && reg_addr == OFS_FLAGS) |=> (reg_rdata[BIT_TXAT-1:BIT_TEF+1] == '0))
      else $error("reserved bits set");
   a_pend_fifo0: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_read && reg_addr == OFS_RX_PEND_LO) |=> ((reg_rdata & ~{{(DATA_W-FIFO_N){1'b0}}, RX_FIFO_MASK}) == ZERO_WORD))
      else $error("pending reserved bits set");
   a_pend_masked: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_read && reg_addr == OFS_RX_PEND_LO && !(|rx_fifo_flag_enables)) |=> (reg_rdata == ZERO_WORD))
      else $error("pending bit without enable");
   a_pend_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (reg_read && reg_addr == OFS_RX_PEND_HI) |=> (reg_rdata == ZERO_WORD))
      else $error("high pending word not zero");

   // enables store only their implemented bits and gate the single request
   a_enable_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_enables |=> (enables == (ENABLE_MASK & $past(reg_wdata))))
      else $error("enable write not stored");
   a_enable_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !wr_enables |=> $stable(enables))
      else $error("enables changed without write");
   a_enable_gap: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (enables & ~ENABLE_MASK) == ZERO_WORD)
      else $error("unimplemented enable bit set");
   a_irq_masked: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (enables == ZERO_WORD) |=> !irq_request)
      else $error("irq with all enables clear");
   a_irq_ivm: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (invalid_message_flag && enables[BIT_IVM]) |=> irq_request)
      else $error("enabled flag gave no irq");
   a_irq_summary: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (|tx_fifo_pending && enables[BIT_TX]) |=> irq_request)
      else $error("enabled summary gave no irq");
   a_irq_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ##1 (irq_request == |($past(flag_word) & $past(enables))))
      else $error("irq mismatch");
endmodule

// ---- testbench/testbench.sv ----
// self-checking testbench for the can interrupt flag and status block
`timescale 1ns/1ps
module testbench;
   import cifs_pkg::*;
   logic              sys_clk;
   logic              sys_rst;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_write;
   logic              reg_read;
   logic [DATA_W-1:0] reg_rdata;
   logic [3:0]        events;      // 3 invalid msg, 2 wake, 1 bus error, 0 system error
   logic [MODE_W-1:0] cur_mode;
   logic [MODE_W-1:0] req_mode;
   logic [TS_W-1:0]   ts_count;
   logic [FIFO_N-1:0] rxf;
   logic [FIFO_N-1:0] rxe;
   logic [FIFO_N-1:0] rxov;
   logic [FIFO_N-1:0] txat;
   logic [FIFO_N-1:0] txp;
   logic              tef;
   logic              irq_request;
   int                fail_count;
   int                compares;

   ////////////////////////////////////////////////////////////////////////////
   cifs_top cifs_top_inst (
      .sys_clk                  (sys_clk),
      .sys_rst                  (sys_rst),
      .reg_addr                 (reg_addr),
      .reg_wdata                (reg_wdata),
      .reg_write                (reg_write),
      .reg_read                 (reg_read),
      .reg_rdata                (reg_rdata),
      .invalid_message_event    (events[3]),
      .wake_activity_event      (events[2]),
      .bus_error_event          (events[1]),
      .system_error_event       (events[0]),
      .current_operating_mode   (cur_mode),
      .requested_operating_mode (req_mode),
      .timestamp_counter        (ts_count),
      .rx_fifo_flags            (rxf),
      .rx_fifo_flag_enables     (rxe),
      .rx_overflow_flags        (rxov),
      .tx_attempt_flags         (txat),
      .tx_event_queue_flag      (tef),
      .tx_fifo_pending          (txp),
      .irq_request              (irq_request)
   );

   ////////////////////////////////////////////////////////////////////////////
   // free-running 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // one-cycle write strobe; strobes never overlap since each task owns its edges
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1;
      check(reg_rdata, exp, what);
   endtask

   task automatic pulse(input int i);
      @(posedge sys_clk);
      events[i] <= 1'b1;
      @(posedge sys_clk);
      events <= 4'h0;
   endtask

   // drive the summary sources, then read flag word and low pending word
   task automatic summ(input logic [FIFO_N-1:0] ov, at, f, e, tp, input logic ef,
                       input logic [DATA_W-1:0] exp_flags, exp_pend);
      @(posedge sys_clk);
      rxov <= ov;
      txat <= at;
      rxf  <= f;
      rxe  <= e;
      txp  <= tp;
      tef  <= ef;
      rd(OFS_FLAGS, exp_flags, "summary flags");
      rd(OFS_RX_PEND_LO, exp_pend, "rx pending low");
   endtask

   task automatic print_verdict();
      $display("compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog: a hung sequence still ends in the verdict
   initial begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      $display("CHECK FAILED at %0t: sequence did not finish", $time);
      print_verdict();
   end

   // main sequence
   initial begin
      fail_count = 0;
      compares   = 0;
      sys_rst    = 1'b1;
      reg_addr   = '0;
      reg_wdata  = '0;
      reg_write  = 1'b0;
      reg_read   = 1'b0;
      events     = 4'h0;
      cur_mode   = 3'h4;       // equals the tracker's reset mode, so no change is seen
      req_mode   = 3'h2;
      ts_count   = '0;
      {rxf, rxe, rxov, txat, txp, tef} = '0;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(OFS_FLAGS, 16'h0000, "flags after reset");
      rd(OFS_ENABLES, 16'h0000, "enables after reset");
      check({15'h0000, irq_request}, 16'h0000, "irq after reset");
      $display("test reset finished");
      // each event sets its own bit; write of one keeps, write of zero clears
      for (int i = 0; i < 4; i++) begin
         pulse(i);
         rd(OFS_FLAGS, 16'h1000 << i, "event flag set");
         wr(OFS_FLAGS, 16'hFFFF);
         rd(OFS_FLAGS, 16'h1000 << i, "flag kept by one");
         wr(OFS_FLAGS, ~(16'h1000 << i));
         rd(OFS_FLAGS, 16'h0000, "flag cleared by zero");
      end
      // event and clear on the same edge: the set must win
      @(posedge sys_clk);
      events    <= 4'h8;
      reg_addr  <= OFS_FLAGS;
      reg_wdata <= 16'h0000;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      events    <= 4'h0;
      reg_write <= 1'b0;
      rd(OFS_FLAGS, 16'h8000, "set beats clear");
      wr(OFS_FLAGS, 16'h0000);
      $display("test event flags finished");
      // mode change: current reaches requested
      rd(OFS_FLAGS, 16'h0000, "no mode flag yet");
      @(posedge sys_clk);
      cur_mode <= 3'h2;
      repeat (3) @(posedge sys_clk);
      rd(OFS_FLAGS, 16'h0008, "mode change flag");
      rd(OFS_MODE, 16'h0012, "mode status");
      wr(OFS_FLAGS, 16'hFFF7);
      rd(OFS_FLAGS, 16'h0000, "mode flag cleared");
      // time base wraps past its maximum
      @(posedge sys_clk);
      ts_count <= TS_MAX;
      @(posedge sys_clk);
      ts_count <= 32'h0000_0000;
      repeat (2) @(posedge sys_clk);
      rd(OFS_FLAGS, 16'h0004, "timer wrap flag");
      wr(OFS_FLAGS, 16'hFFFB);
      rd(OFS_FLAGS, 16'h0000, "timer flag cleared");
      $display("test mode and timer finished");
      // summaries: fifo 0 never counts for receive overflow or receive pending
      summ(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0000, 16'h0000);
      summ(8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0800, 16'h0000);
      summ(8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0400, 16'h0000);
      summ(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 16'h0010, 16'h0000);
      summ(8'h00, 8'h00, 8'hFF, 8'h01, 8'h00, 1'b0, 16'h0000, 16'h0000);
      summ(8'h00, 8'h00, 8'h0F, 8'hFF, 8'h00, 1'b0, 16'h0002, 16'h000E);
      summ(8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 1'b0, 16'h0001, 16'h0000);
      summ(8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 1'b1, 16'h0C13, 16'h00FE);
      rd(OFS_RX_PEND_HI, 16'h0000, "rx pending high");
      wr(OFS_RX_PEND_LO, 16'h0000);
      rd(OFS_RX_PEND_LO, 16'h00FE, "pending ignores writes");
      wr(OFS_FLAGS, 16'h0000);
      rd(OFS_FLAGS, 16'h0C13, "summaries ignore writes");
      summ(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0000, 16'h0000);
      $display("test summaries finished");
      // enables and the single interrupt request
      wr(OFS_ENABLES, 16'hFFFF);
      rd(OFS_ENABLES, ENABLE_MASK, "enable bits 9..5 not stored");
      @(posedge sys_clk);
      #1;
      check(reg_rdata, 16'h0000, "read data lasts one cycle");
      check({15'h0000, irq_request}, 16'h0000, "no irq without flag");
      pulse(3);
      rd(OFS_FLAGS, 16'h8000, "invalid message flag");
      check({15'h0000, irq_request}, 16'h0001, "irq from enabled flag");
      wr(OFS_ENABLES, 16'h7FFF);
      repeat (2) @(posedge sys_clk);
      #1;
      check({15'h0000, irq_request}, 16'h0000, "masked flag gives no irq");
      @(posedge sys_clk);
      txp <= 8'h04;
      repeat (3) @(posedge sys_clk);
      #1;
      check({15'h0000, irq_request}, 16'h0001, "irq from summary");
      wr(OFS_ENABLES, 16'h0000);
      repeat (2) @(posedge sys_clk);
      #1;
      check({15'h0000, irq_request}, 16'h0000, "all masked");
      rd(4'hF, 16'h0000, "unmapped read");
      $display("test interrupt request finished");
      print_verdict();
   end
endmodule
